// [rtl/ivs_top.sv]
// Interrupt vector offset and shadow register set selector
//
// Behaviour
// - Each interrupt has its own offset register, field bits 17:1, from exception base.
// - Seven shadow sets; each priority level from 1 to 7 has a 4-bit set selection field; level 0 has none.
// - Selection codes 0000 to 0111 pick the set numbered by the code.
// - Codes with top bit set are reserved and fall back to set 0.
// - Bit 0 of shadow select register: single vector uses a shadow set.
// - Status register shows read-only number of the last serviced request.
`timescale 1ns/1ps
module ivs_top (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESETN,
  input  wire logic [11:0] I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  input  wire logic        I_TAKE,
  input  wire logic [7:0]  I_TAKE_IRQ,
  input  wire logic [2:0]  I_TAKE_PRIO,
  output logic             O_VEC_VALID,
  output logic      [17:0] O_VEC_OFFSET,
  output logic      [31:0] O_VEC_ADDR,
  output logic      [2:0]  O_VEC_SHADOW,
  output logic             O_VEC_USE_SHADOW
);
  typedef enum logic [1:0] {
    IVS_ST_IDLE   = 2'b01,
    IVS_ST_LOOKUP = 2'b10
  } ivs_state_t;

  ivs_mem_if mem_if ();

  ivs_offset_mem u_mem (
    .i_clk    (I_CLK_SYS),
    .i_resetn (I_RESETN),
    .mem_if   (mem_if)
  );

  // Reserved codes are not an error; they quietly map to the normal set
  function automatic logic [2:0] shadow_of(input logic [3:0] code);
    if (code[3]) begin
      return ivs_pkg::SET_DEFAULT;
    end
    return code[2:0];
  endfunction

  function automatic logic is_voff(input logic [11:0] addr);
    return addr[11:10] == ivs_pkg::VOFF_REGION;
  endfunction

  logic [31:0] shadow_sel;
  logic [31:0] next_shadow_sel;
  logic [31:0] exc_base;
  logic [31:0] next_exc_base;
  logic        multi;
  logic        next_multi;
  logic [7:0]  serviced_request_number;
  logic [7:0]  next_serviced_request_number;
  ivs_state_t  state;
  ivs_state_t  next_state;
  logic [2:0]  prio_q;
  logic [2:0]  next_prio_q;
  logic        next_vec_valid;
  logic [17:0] next_vec_offset;
  logic [31:0] next_vec_addr;
  logic [2:0]  next_vec_shadow;
  logic        next_vec_use_shadow;
  logic [3:0]  level_code [ivs_pkg::NUM_PRIO];
  logic [2:0]  level_set;

  // Priority 0 never interrupts, so it carries no field of its own
  genvar g;
  generate
    for (g = 0; g < ivs_pkg::NUM_PRIO; g++) begin : g_level
      if (g == 0) begin : g_none
        assign level_code[g] = 4'h0;
      end else begin : g_field
        assign level_code[g] = shadow_sel[g*ivs_pkg::SEL_W +: ivs_pkg::SEL_W];
      end
    end
  endgenerate

  // Register writes
  always_comb begin
    next_shadow_sel = shadow_sel;
    next_exc_base   = exc_base;
    next_multi      = multi;
    if (I_WR) begin
      case (I_ADDR)
        ivs_pkg::SHADOW_SEL_OFF: begin
          next_shadow_sel = I_WDATA & ivs_pkg::SHADOW_SEL_MASK;
        end
        ivs_pkg::EXC_BASE_OFF: begin
          next_exc_base = I_WDATA;
        end
        ivs_pkg::CTRL_OFF: begin
          next_multi = I_WDATA[ivs_pkg::MULTI_BIT];
        end
        default: begin
          next_multi = multi;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      shadow_sel <= ivs_pkg::SHADOW_SEL_RST;
      exc_base   <= ivs_pkg::EXC_BASE_RST;
      multi      <= ivs_pkg::MULTI_RST;
    end else begin
      shadow_sel <= next_shadow_sel;
      exc_base   <= next_exc_base;
      multi      <= next_multi;
    end
  end

  // Memory and read port steering; read data come out of the memory's port A flop
  always_comb begin
    mem_if.wr_en     = I_WR && is_voff(I_ADDR);
    mem_if.wr_idx    = I_ADDR[9:2];
    mem_if.wr_data   = I_WDATA[ivs_pkg::VOFF_MSB:ivs_pkg::VOFF_LSB];
    mem_if.a_en      = I_RD;
    mem_if.a_idx     = I_ADDR[9:2];
    mem_if.a_sel_mem = is_voff(I_ADDR);
    mem_if.b_idx     = I_TAKE_IRQ;
    case (I_ADDR)
      ivs_pkg::SHADOW_SEL_OFF: mem_if.a_alt = shadow_sel;
      ivs_pkg::STATUS_OFF:     mem_if.a_alt = {24'h000000, serviced_request_number};
      ivs_pkg::EXC_BASE_OFF:   mem_if.a_alt = exc_base;
      ivs_pkg::CTRL_OFF:       mem_if.a_alt = {31'h00000000, multi};
      default:                 mem_if.a_alt = 32'h00000000;
    endcase
  end

  assign O_RDATA = mem_if.a_data;

  // Take pipeline: offset lookup in the first cycle, vector out in the second
  always_comb begin
    next_state  = IVS_ST_IDLE;
    next_prio_q = prio_q;
    next_serviced_request_number   = serviced_request_number;
    if (I_TAKE) begin
      next_state  = IVS_ST_LOOKUP;
      next_prio_q = I_TAKE_PRIO;
      next_serviced_request_number   = I_TAKE_IRQ;
    end
  end

  assign level_set = shadow_of(level_code[prio_q]);

  always_comb begin
    next_vec_valid      = 1'b0;
    next_vec_offset     = O_VEC_OFFSET;
    next_vec_addr       = O_VEC_ADDR;
    next_vec_shadow     = O_VEC_SHADOW;
    next_vec_use_shadow = O_VEC_USE_SHADOW;
    case (state)
      IVS_ST_LOOKUP: begin
        next_vec_valid = 1'b1;
        if (multi) begin
          next_vec_offset     = {mem_if.b_data, 1'b0};
          next_vec_shadow     = level_set;
          next_vec_use_shadow = level_set != ivs_pkg::SET_DEFAULT;
        end else begin
          // Single vector: every request enters at the base itself
          next_vec_offset     = 18'h00000;
          next_vec_use_shadow = shadow_sel[ivs_pkg::SS_BIT];
          next_vec_shadow     = shadow_sel[ivs_pkg::SS_BIT] ? level_set
                                                            : ivs_pkg::SET_DEFAULT;
        end
        next_vec_addr = exc_base + {14'h0000, next_vec_offset};
      end
      IVS_ST_IDLE: begin
        next_vec_valid = 1'b0;
      end
      default: begin
        next_vec_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state            <= IVS_ST_IDLE;
      prio_q           <= 3'h0;
      serviced_request_number             <= ivs_pkg::SERVICED_REQUEST_NUMBER_RST;
      O_VEC_VALID      <= 1'b0;
      O_VEC_OFFSET     <= 18'h00000;
      O_VEC_ADDR       <= 32'h00000000;
      O_VEC_SHADOW     <= ivs_pkg::SET_DEFAULT;
      O_VEC_USE_SHADOW <= 1'b0;
    end else begin
      state            <= next_state;
      prio_q           <= next_prio_q;
      serviced_request_number             <= next_serviced_request_number;
      O_VEC_VALID      <= next_vec_valid;
      O_VEC_OFFSET     <= next_vec_offset;
      O_VEC_ADDR       <= next_vec_addr;
      O_VEC_SHADOW     <= next_vec_shadow;
      O_VEC_USE_SHADOW <= next_vec_use_shadow;
    end
  end
endmodule

// [rtl/ivs_pkg.sv]
// Constants for the interrupt vector and shadow set selector
package ivs_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          IRQ_W           = 8;
  localparam int          NUM_IRQ         = 256;
  localparam int          PRIO_W          = 3;
  localparam int          NUM_PRIO        = 8;
  localparam int          SEL_W           = 4;
  localparam int          SET_W           = 3;
  localparam int          VOFF_W          = 17;
  localparam int          VOFF_LSB        = 1;
  localparam int          VOFF_MSB        = 17;
  localparam int          SERVICED_REQUEST_NUMBER_LSB        = 0;
  localparam int          SERVICED_REQUEST_NUMBER_MSB        = 7;
  localparam int          SS_BIT          = 0;
  localparam int          MULTI_BIT       = 0;
  localparam logic [11:0] SHADOW_SEL_OFF  = 12'h000;
  localparam logic [11:0] STATUS_OFF      = 12'h004;
  localparam logic [11:0] EXC_BASE_OFF    = 12'h008;
  localparam logic [11:0] CTRL_OFF        = 12'h00C;
  localparam logic [1:0]  VOFF_REGION     = 2'h1;
  localparam logic [31:0] SHADOW_SEL_RST  = 32'h00000000;
  localparam logic [31:0] SHADOW_SEL_MASK = 32'hFFFFFFF1;
  localparam logic [31:0] EXC_BASE_RST    = 32'h00000000;
  localparam logic        MULTI_RST       = 1'b1;
  localparam logic [7:0]  SERVICED_REQUEST_NUMBER_RST        = 8'h00;
  localparam logic [16:0] VOFF_RST        = 17'h00000;
  localparam logic [2:0]  SET_DEFAULT     = 3'h0;
endpackage

// [rtl/ivs_mem_if.sv]
// Carrier between the selector and its vector offset memory
`timescale 1ns/1ps
interface ivs_mem_if;
  logic        wr_en;
  logic [7:0]  wr_idx;
  logic [16:0] wr_data;
  logic        a_en;
  logic [7:0]  a_idx;
  logic        a_sel_mem;
  logic [31:0] a_alt;
  logic [31:0] a_data;
  logic [7:0]  b_idx;
  logic [16:0] b_data;
  modport ctrl (output wr_en, wr_idx, wr_data, a_en, a_idx, a_sel_mem, a_alt, b_idx,
                input  a_data, b_data);
  modport mem  (input  wr_en, wr_idx, wr_data, a_en, a_idx, a_sel_mem, a_alt, b_idx,
                output a_data, b_data);
endinterface

// [rtl/ivs_offset_mem.sv]
// Per-interrupt vector offset storage with registered read ports
`timescale 1ns/1ps
module ivs_offset_mem (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  ivs_mem_if.mem    mem_if
);
  logic [16:0] store [ivs_pkg::NUM_IRQ];
  logic [31:0] next_a_data;
  logic [16:0] next_b_data;

  // Port A also carries the plain registers so bus data leaves one flop
  always_comb begin
    next_a_data = '0;
    if (mem_if.a_en) begin
      if (mem_if.a_sel_mem) begin
        next_a_data = {14'h0000, store[mem_if.a_idx], 1'b0};
      end else begin
        next_a_data = mem_if.a_alt;
      end
    end
    next_b_data = store[mem_if.b_idx];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int k = 0; k < ivs_pkg::NUM_IRQ; k++) begin
        store[k] <= ivs_pkg::VOFF_RST;
      end
      mem_if.a_data <= '0;
      mem_if.b_data <= ivs_pkg::VOFF_RST;
    end else begin
      if (mem_if.wr_en) begin
        store[mem_if.wr_idx] <= mem_if.wr_data;
      end
      mem_if.a_data <= next_a_data;
      mem_if.b_data <= next_b_data;
    end
  end
endmodule

// [sim/ivs_assertions.sv]
// Port-level checks for the vector and shadow set selector
`timescale 1ns/1ps
module ivs_assertions (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RESETN,
  input wire logic [11:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic        I_TAKE,
  input wire logic [7:0]  I_TAKE_IRQ,
  input wire logic [2:0]  I_TAKE_PRIO,
  input wire logic        O_VEC_VALID,
  input wire logic [17:0] O_VEC_OFFSET,
  input wire logic [31:0] O_VEC_ADDR,
  input wire logic [2:0]  O_VEC_SHADOW,
  input wire logic        O_VEC_USE_SHADOW
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESETN);
  sequence s_vec;
    ##2 O_VEC_VALID;
  endsequence
  sequence s_rd_stat;
    I_RD && I_ADDR == 12'h004;
  endsequence
  property p_answer;
    I_TAKE |-> s_vec;
  endproperty
  a_answer: assert property (p_answer) else $error("take without vector");
  property p_cause;
    O_VEC_VALID |-> $past(I_TAKE, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("vector without take");
  property p_hold;
    !O_VEC_VALID |-> $stable(O_VEC_ADDR) && $stable(O_VEC_SHADOW) && $stable(O_VEC_OFFSET)
      && $stable(O_VEC_USE_SHADOW);
  endproperty
  a_hold: assert property (p_hold) else $error("vector moved");
  property p_even;
    O_VEC_OFFSET[0] == 1'b0;
  endproperty
  a_even: assert property (p_even) else $error("odd offset");
  property p_use;
    O_VEC_VALID && O_VEC_SHADOW != 3'h0 |-> O_VEC_USE_SHADOW;
  endproperty
  a_use: assert property (p_use) else $error("set without use flag");
  property p_stat;
    s_rd_stat |=> O_RDATA[31:8] == 24'h000000;
  endproperty
  a_stat: assert property (p_stat) else $error("status upper bits");
  property p_offrd;
    I_RD && I_ADDR[11:10] == 2'h1 |=> O_RDATA[31:18] == 14'h0000 && !O_RDATA[0];
  endproperty
  a_offrd: assert property (p_offrd) else $error("offset spare bits");
  property p_ssrd;
    I_RD && I_ADDR == 12'h000 |=> O_RDATA[3:1] == 3'h0;
  endproperty
  a_ssrd: assert property (p_ssrd) else $error("select spare bits");
endmodule
bind ivs_top ivs_assertions i_chk (.I_CLK_SYS, .I_RESETN, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .O_RDATA, .I_TAKE, .I_TAKE_IRQ, .I_TAKE_PRIO, .O_VEC_VALID, .O_VEC_OFFSET, .O_VEC_ADDR,
  .O_VEC_SHADOW, .O_VEC_USE_SHADOW);

// [sim/ivs_core_model.sv]
// Core model that takes vectored interrupts
`timescale 1ns/1ps
module ivs_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_go,
  input  wire logic [7:0]  i_irq,
  input  wire logic [2:0]  i_prio,
  input  wire logic [31:0] i_base,
  input  wire logic        i_vec_valid,
  input  wire logic [17:0] i_vec_offset,
  output logic             o_take,
  output logic      [7:0]  o_take_irq,
  output logic      [2:0]  o_take_prio,
  output logic      [31:0] o_pc,
  output logic             o_done
);
  // Fields inverted outside a take so stale values never match
  assign o_take_irq  = o_take ? i_irq : ~i_irq;
  assign o_take_prio = o_take ? i_prio : ~i_prio;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_take <= 1'b0;
      o_done <= 1'b0;
      o_pc   <= 32'h00000000;
    end else begin
      o_take <= i_go;
      o_done <= i_vec_valid;
      if (i_vec_valid) o_pc <= i_base + {14'h0000, i_vec_offset};
    end
  end
endmodule

// [sim/ivs_top_test.sv]
// Self-checking bench for the vector and shadow set selector
`timescale 1ns/1ps
module ivs_top_test;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic        take, vv, use_sh, done;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, vaddr, pc, eo;
  logic [31:0] base = 32'h40000000;
  logic [17:0] voff;
  logic [7:0]  irq = 8'h00, t_irq;
  logic [2:0]  prio = 3'h0, t_prio, vsh, es;
  int          failures = 0, tests_run = 0;
  always #2 clk = ~clk;
  ivs_top i_dut (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_TAKE(take), .I_TAKE_IRQ(t_irq), .I_TAKE_PRIO(t_prio),
    .O_VEC_VALID(vv), .O_VEC_OFFSET(voff), .O_VEC_ADDR(vaddr), .O_VEC_SHADOW(vsh),
    .O_VEC_USE_SHADOW(use_sh));
  ivs_core_model i_core (.i_clk(clk), .i_resetn(rstn), .i_go(go), .i_irq(irq), .i_prio(prio),
    .i_base(base), .i_vec_valid(vv), .i_vec_offset(voff), .o_take(take), .o_take_irq(t_irq),
    .o_take_prio(t_prio), .o_pc(pc), .o_done(done));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask
  task automatic tk(input logic [7:0] n, input logic [2:0] p);
    @(posedge clk);
    irq <= n;
    prio <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 16 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      failures++;
      end_sim;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rc(12'h00C, 32'h00000001);
    rc(12'h000, 32'h00000000);
    rc(12'h010, 32'h00000000);
    wr_reg(12'h004, 32'hFFFFFFFF);
    rc(12'h004, 32'h00000000);
    wr_reg(12'h008, base);
    rc(12'h008, base);
    rc(12'h404, 32'h00000000);
    wr_reg(12'h7FC, 32'hFFFFFFFF);
    wr_reg(12'h400, 32'h00000002);
    rc(12'h7FC, 32'h0003FFFE);
    wr_reg(12'h000, 32'h0000387F);
    rc(12'h000, 32'h00003871);
    $display("test registers done");
    // Every code on one level, reserved ones included
    for (int c = 0; c < 16; c++) begin
      wr_reg(12'h000, 32'h00003871 | (c << 16));
      tk(c[0] ? 8'hFF : 8'h00, 3'h4);
      eo = c[0] ? 32'h0003FFFE : 32'h00000002;
      es = c[3] ? 3'h0 : c[2:0];
      chk("shadow", {29'h0, vsh}, {29'h0, es});
      chk("use", {31'h0, use_sh}, {31'h0, es != 3'h0});
      chk("offset", {14'h0, voff}, eo);
      chk("vaddr", vaddr, base + eo);
      chk("pc", pc, base + eo);
      rc(12'h004, c[0] ? 32'h000000FF : 32'h00000000);
    end
    // Lower levels 0 to 3 keep their own fields; level 0 has none
    for (int p = 0; p < 4; p++) begin
      tk(8'h00, p[2:0]);
      es = (p == 1) ? 3'h7 : ((p == 3) ? 3'h3 : 3'h0);
      chk("level", {29'h0, vsh}, {29'h0, es});
    end
    $display("test multi vector done");
    wr_reg(12'h00C, 32'h00000000);
    rc(12'h00C, 32'h00000000);
    for (int c = 0; c < 2; c++) begin
      wr_reg(12'h000, 32'h00003870 | c);
      tk(8'hFF, 3'h1);
      chk("s_off", {14'h0, voff}, 32'h00000000);
      chk("s_use", {31'h0, use_sh}, c);
      chk("s_set", {29'h0, vsh}, c ? 32'h00000007 : 32'h00000000);
      chk("s_addr", vaddr, base);
    end
    $display("test single vector done");
    end_sim;
  end
endmodule
